// ### eeprom_cmd_pkg.sv
// shared constants and types of the three-wire eeprom command port
package eeprom_cmd_pkg;

   // ********************************************************************
   // instruction framing
   // ********************************************************************
   localparam logic START_BIT = 1'b1;
   localparam int OPCODE_W = 2;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [1:0] OP_ERASE = 2'b11;
   localparam logic [1:0] OP_SPECIAL = 2'b00;
   // selectors held in the two top address bits of a special instruction
   localparam logic [1:0] SPC_UNLOCK = 2'b11;
   localparam logic [1:0] SPC_CLEAR_ALL = 2'b10;
   localparam logic [1:0] SPC_FILL_ALL = 2'b01;
   localparam logic [1:0] SPC_LOCK = 2'b00;

   // ********************************************************************
   // geometry
   // ********************************************************************
   localparam int DENSITY_DEFAULT_KBIT = 1;
   localparam int WORDS_PER_KBIT = 64;
   localparam int ADDR_W_SMALL = 7;
   localparam int ADDR_W_LARGE = 9;
   localparam int HDR_W = OPCODE_W + ADDR_W_LARGE;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [1:0] LANES_BOTH = 2'b11;

   // ********************************************************************
   // output levels
   // ********************************************************************
   localparam logic DUMMY_BIT = 1'b0;
   localparam logic STATUS_BUSY = 1'b0;
   localparam logic STATUS_READY = 1'b1;

   // ********************************************************************
   // timing
   // ********************************************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PROG_TIME_MS = 10;
   // longest time; dividing first keeps the product inside 32 bits
   localparam int PROG_CYCLES = PROG_TIME_MS * (1000000000 / CLK_PERIOD_PS);

   // ********************************************************************
   // receive sequencer states
   // ********************************************************************
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_HDR = 4'b0010,
      S_DATA = 4'b0100,
      S_READ = 4'b1000
   } rx_state_t;

endpackage

// ### pin_sync.sv
// two-flop synchronisers for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 4
) (
   // system
   input wire logic clk_sys,
   input wire logic rstn,
   // asynchronous pins and their synchronised copies
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] pinOut
);

   logic [W-1:0] meta_q;

   // the first stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         pinOut <= '0;
      end else begin
         meta_q <= pinIn;
         pinOut <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ### eeprom_array.sv
// word memory with two byte lanes and a registered read port
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
   parameter int DEPTH = 64,
   parameter int IDX_W = 6
) (
   // system
   input wire logic clk_sys,
   input wire logic rstn,
   // write port
   input wire logic wrEn,
   input wire logic [IDX_W-1:0] wrIdx,
   input wire logic [1:0] wrLanes,
   input wire logic [15:0] wrData,
   // read port
   input wire logic [IDX_W-1:0] rdIdx,
   output logic [15:0] rdData
);

   logic [15:0] cells [DEPTH];

   // lane-masked write; contents are not cleared by reset
   always_ff @(posedge clk_sys) begin
      if (wrEn && wrLanes[0]) begin
         cells[wrIdx][7:0] <= wrData[7:0];
      end
      if (wrEn && wrLanes[1]) begin
         cells[wrIdx][15:8] <= wrData[15:8];
      end
   end

   // read data always come from a register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdData <= 16'h0000;
      end else begin
         rdData <= cells[rdIdx];
      end
   end

endmodule
`default_nettype wire

// ### three_wire_eeprom_command_port.sv
// command port of a three-wire serial eeprom with self-timed programming
//
// Overview of operation
// - two-bit opcode follows: 10 read, 01 write, 11 erase, 00 special.
// - special: top address bits 11 unlock, 10 clear all, 01 fill all, 00 lock.
// - address is 7/6 bits small density, 9/8 bits larger; middle ignores top.
// - after read address, addressed word is shifted out one bit per clock.
// - output data change on the rising serial clock edge.
// - a dummy zero is driven while the last read address bit shifts in.
// - after power-on, erase and write are rejected until unlocked.
// - unlock persists over instructions until a lock command or power loss.
// - lock blocks every erase and program from changing the array.
// - reads work whether or not programming is unlocked.
// - erase starts a timed cycle after its address, setting the word to ones.
// - write takes 16 or 8 data bits, then the timed cycle starts.
// - clear all sets every bit of the array to one.
// - fill all programs every location with the one data word given.
// - in status mode output reads zero while busy, one when done.
// - after the cycle ended and standby resumed, no status is shown.
// - width select high gives 16-bit words, low gives 8-bit bytes.
// - each timed erase or write cycle completes within 10 ms.
`timescale 1ns/1ps
`default_nettype none
module three_wire_eeprom_command_port #(
   parameter int DENSITY_KBIT = eeprom_cmd_pkg::DENSITY_DEFAULT_KBIT,
   parameter int PROG_CYCLES = eeprom_cmd_pkg::PROG_CYCLES
) (
   // system
   input wire logic clk_sys,
   input wire logic rstn,
   // serial link from the host
   input wire logic chipSelect,
   input wire logic serialClockIn,
   input wire logic serialIn,
   // organisation strap
   input wire logic widthSelect,
   // serial data back to the host
   output logic serialOut,
   output logic serialOutEn
);

   // ********************************************************************
   // geometry derived from the density
   // ********************************************************************
   localparam int ADDR_W = (DENSITY_KBIT == 1) ? eeprom_cmd_pkg::ADDR_W_SMALL :
                                                 eeprom_cmd_pkg::ADDR_W_LARGE;
   localparam int DEPTH = DENSITY_KBIT * eeprom_cmd_pkg::WORDS_PER_KBIT;
   localparam int IDX_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(PROG_CYCLES + 1);
   localparam int HDR_W = eeprom_cmd_pkg::HDR_W;

   // the sweep of a whole-array command must fit inside the timed cycle
   generate
      if (!(DENSITY_KBIT == 1 || DENSITY_KBIT == 2 || DENSITY_KBIT == 4)) begin : g_bad_density
         $error("density must be 1, 2 or 4 kbit");
      end
      if (PROG_CYCLES < DEPTH) begin : g_bad_cycles
         $error("programming cycle shorter than the array sweep");
      end
   endgenerate

   // ********************************************************************
   // decoding helpers
   // ********************************************************************
   // word index of an address; byte mode drops the lane bit, and the
   // truncation drops the unused top bit of the middle density
   function automatic logic [IDX_W-1:0] idxOf(input logic wordMode,
                                              input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] shifted;
      shifted = wordMode ? addr : (addr >> 1);
      return shifted[IDX_W-1:0];
   endfunction

   // lanes touched by a single-location program
   function automatic logic [1:0] lanesOf(input logic wordMode,
                                          input logic [ADDR_W-1:0] addr);
      if (wordMode) begin
         return eeprom_cmd_pkg::LANES_BOTH;
      end
      return addr[0] ? 2'b10 : 2'b01;
   endfunction

   // ********************************************************************
   // pin synchronisation and edge detection
   // ********************************************************************
   logic [3:0] pinSync;
   logic csOn;
   logic skLevel;
   logic diBit;
   logic wordOrg;
   logic skLast_q;
   logic csLast_q;
   logic skRise;
   logic csRise;
   logic csFall;

   pin_sync #(
      .W(4)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pinIn({chipSelect, serialClockIn, serialIn, widthSelect}),
      .pinOut(pinSync)
   );

   assign csOn = pinSync[3];
   assign skLevel = pinSync[2];
   assign diBit = pinSync[1];
   assign wordOrg = pinSync[0];

   // data pin shares the clock pin's latency, so it is sampled in step
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         skLast_q <= 1'b0;
         csLast_q <= 1'b0;
      end else begin
         skLast_q <= skLevel;
         csLast_q <= csOn;
      end
   end

   assign skRise = skLevel && !skLast_q && csOn;
   assign csRise = csOn && !csLast_q;
   assign csFall = !csOn && csLast_q;

   // ********************************************************************
   // field decode
   // ********************************************************************
   eeprom_cmd_pkg::rx_state_t state_q;
   logic [HDR_W-1:0] hdrShift_q;
   logic [3:0] hdrCnt_q;
   logic [15:0] dataShift_q;
   logic [4:0] dataCnt_q;
   logic [4:0] outCnt_q;
   logic [15:0] outShift_q;
   logic [ADDR_W-1:0] addr_q;
   logic fillMode_q;
   logic unlocked_q;
   logic busy_q;
   logic statusMode_q;

   int addrLen;
   int dataLen;
   logic [HDR_W-1:0] hdrNext;
   logic [15:0] dataNext;
   logic [ADDR_W-1:0] addrMask;
   logic [ADDR_W-1:0] addrField;
   logic [1:0] opCode;
   logic [1:0] special;
   logic startBit;
   logic hdrLast;
   logic dataLast;

   // field lengths follow the organisation strap
   assign addrLen = wordOrg ? ADDR_W - 1 : ADDR_W;
   assign dataLen = wordOrg ? eeprom_cmd_pkg::WORD_W : eeprom_cmd_pkg::BYTE_W;
   assign addrMask = ADDR_W'((1 << addrLen) - 1);
   assign hdrNext = {hdrShift_q[HDR_W-2:0], diBit};
   assign dataNext = {dataShift_q[14:0], diBit};
   assign opCode = 2'(hdrNext >> addrLen);
   assign special = 2'(hdrNext >> (addrLen - 2));
   assign addrField = ADDR_W'(hdrNext) & addrMask;

   // zeros are skipped until a one arrives, and nothing starts while busy
   assign startBit = (state_q == eeprom_cmd_pkg::S_IDLE) && skRise &&
                     (diBit == eeprom_cmd_pkg::START_BIT) && !busy_q;
   assign hdrLast = (state_q == eeprom_cmd_pkg::S_HDR) && skRise &&
                    (hdrCnt_q == 4'(addrLen + eeprom_cmd_pkg::OPCODE_W - 1));
   assign dataLast = (state_q == eeprom_cmd_pkg::S_DATA) && skRise &&
                     (dataCnt_q == 5'(dataLen - 1));

   // ********************************************************************
   // receive sequencer
   // ********************************************************************
   // dropping select abandons whatever was half received
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= eeprom_cmd_pkg::S_IDLE;
      end else if (!csOn) begin
         state_q <= eeprom_cmd_pkg::S_IDLE;
      end else begin
         unique case (state_q)
            eeprom_cmd_pkg::S_IDLE: begin
               if (startBit) begin
                  state_q <= eeprom_cmd_pkg::S_HDR;
               end
            end
            eeprom_cmd_pkg::S_HDR: begin
               if (hdrLast) begin
                  if (opCode == eeprom_cmd_pkg::OP_READ) begin
                     state_q <= eeprom_cmd_pkg::S_READ;
                  end else if (opCode == eeprom_cmd_pkg::OP_WRITE ||
                               (opCode == eeprom_cmd_pkg::OP_SPECIAL &&
                                special == eeprom_cmd_pkg::SPC_FILL_ALL)) begin
                     state_q <= eeprom_cmd_pkg::S_DATA;
                  end else begin
                     state_q <= eeprom_cmd_pkg::S_IDLE;
                  end
               end
            end
            eeprom_cmd_pkg::S_DATA: begin
               if (dataLast) begin
                  state_q <= eeprom_cmd_pkg::S_IDLE;
               end
            end
            eeprom_cmd_pkg::S_READ: begin
               state_q <= eeprom_cmd_pkg::S_READ; // streams until select drops
            end
         endcase
      end
   end

   // header shifter counts opcode and the full address field
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hdrShift_q <= '0;
         hdrCnt_q <= 4'h0;
      end else if (startBit) begin
         hdrShift_q <= '0;
         hdrCnt_q <= 4'h0;
      end else if (state_q == eeprom_cmd_pkg::S_HDR && skRise) begin
         hdrShift_q <= hdrNext;
         hdrCnt_q <= hdrCnt_q + 4'h1;
      end
   end

   // data shifter for write and fill all
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dataShift_q <= 16'h0000;
         dataCnt_q <= 5'h00;
      end else if (hdrLast) begin
         dataShift_q <= 16'h0000;
         dataCnt_q <= 5'h00;
      end else if (state_q == eeprom_cmd_pkg::S_DATA && skRise) begin
         dataShift_q <= dataNext;
         dataCnt_q <= dataCnt_q + 5'h01;
      end
   end

   // address and the kind of pending data phase
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addr_q <= '0;
         fillMode_q <= 1'b0;
      end else if (hdrLast) begin
         addr_q <= addrField;
         fillMode_q <= (opCode == eeprom_cmd_pkg::OP_SPECIAL);
      end else if (state_q == eeprom_cmd_pkg::S_READ && skRise &&
                   outCnt_q == 5'(dataLen - 1)) begin
         addr_q <= (addr_q + ADDR_W'(1)) & addrMask; // sequential read wraps
      end
   end

   // program protection: locked from power-on, changed only by its commands
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         unlocked_q <= 1'b0;
      end else if (hdrLast && opCode == eeprom_cmd_pkg::OP_SPECIAL) begin
         if (special == eeprom_cmd_pkg::SPC_UNLOCK) begin
            unlocked_q <= 1'b1;
         end else if (special == eeprom_cmd_pkg::SPC_LOCK) begin
            unlocked_q <= 1'b0;
         end
      end
   end

   // ********************************************************************
   // self-timed programming
   // ********************************************************************
   logic startProg;
   logic startAll;
   logic [IDX_W-1:0] startIdx;
   logic [1:0] startLanes;
   logic [15:0] startData;
   logic [CNT_W-1:0] busyCnt_q;
   logic sweep_q;
   logic [IDX_W-1:0] sweepIdx_q;
   logic [IDX_W-1:0] sweepEnd_q;
   logic [1:0] progLanes_q;
   logic [15:0] progData_q;
   logic [15:0] rdData;

   // what starts a cycle, gated by the protection state
   always_comb begin
      startProg = 1'b0;
      startAll = 1'b0;
      startIdx = idxOf(wordOrg, addrField);
      startLanes = eeprom_cmd_pkg::LANES_BOTH;
      startData = eeprom_cmd_pkg::ERASED_WORD;
      if (hdrLast && unlocked_q && opCode == eeprom_cmd_pkg::OP_ERASE) begin
         startProg = 1'b1;
         startLanes = lanesOf(wordOrg, addrField);
      end else if (hdrLast && unlocked_q && opCode == eeprom_cmd_pkg::OP_SPECIAL &&
                   special == eeprom_cmd_pkg::SPC_CLEAR_ALL) begin
         startProg = 1'b1;
         startAll = 1'b1;
      end else if (dataLast && unlocked_q) begin
         startProg = 1'b1;
         startAll = fillMode_q;
         startIdx = idxOf(wordOrg, addr_q);
         startLanes = fillMode_q ? eeprom_cmd_pkg::LANES_BOTH : lanesOf(wordOrg, addr_q);
         startData = wordOrg ? dataNext : {dataNext[7:0], dataNext[7:0]};
      end
   end

   // busy for the full cycle; the array is swept one word per clock meanwhile
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         busyCnt_q <= '0;
      end else if (startProg) begin
         busy_q <= 1'b1;
         busyCnt_q <= '0;
      end else if (busy_q) begin
         busyCnt_q <= busyCnt_q + CNT_W'(1);
         if (busyCnt_q == CNT_W'(PROG_CYCLES - 1)) begin
            busy_q <= 1'b0;
         end
      end
   end

   // single commands sweep one word, whole-array commands sweep them all
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sweep_q <= 1'b0;
         sweepIdx_q <= '0;
         sweepEnd_q <= '0;
         progLanes_q <= 2'h0;
         progData_q <= 16'h0000;
      end else if (startProg) begin
         sweep_q <= 1'b1;
         sweepIdx_q <= startAll ? '0 : startIdx;
         sweepEnd_q <= startAll ? IDX_W'(DEPTH - 1) : startIdx;
         progLanes_q <= startLanes;
         progData_q <= startData;
      end else if (sweep_q) begin
         if (sweepIdx_q == sweepEnd_q) begin
            sweep_q <= 1'b0;
         end else begin
            sweepIdx_q <= sweepIdx_q + IDX_W'(1);
         end
      end
   end

   eeprom_array #(
      .DEPTH(DEPTH),
      .IDX_W(IDX_W)
   ) u_array (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wrEn(sweep_q),
      .wrIdx(sweepIdx_q),
      .wrLanes(progLanes_q),
      .wrData(progData_q),
      .rdIdx(idxOf(wordOrg, addr_q)),
      .rdData(rdData)
   );

   // ********************************************************************
   // ready/busy status
   // ********************************************************************
   // entered only by re-raising select while busy, so a cycle that ended
   // with select low leaves nothing to poll
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         statusMode_q <= 1'b0;
      end else if (csRise && busy_q) begin
         statusMode_q <= 1'b1;
      end else if (csFall || startBit) begin
         statusMode_q <= 1'b0;
      end
   end

   // ********************************************************************
   // serial output
   // ********************************************************************
   logic [15:0] firstWord;

   // the byte lane lands in the top half so shifting always starts at bit 15
   assign firstWord = wordOrg ? rdData :
                      {(addr_q[0] ? rdData[15:8] : rdData[7:0]), 8'h00};

   // every read data change is taken on a rising serial clock edge; status follows busy
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
         outShift_q <= 16'h0000;
         outCnt_q <= 5'h00;
      end else if (!csOn) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
         outCnt_q <= 5'h00;
      end else if (statusMode_q) begin
         serialOutEn <= 1'b1;
         serialOut <= busy_q ? eeprom_cmd_pkg::STATUS_BUSY :
                               eeprom_cmd_pkg::STATUS_READY;
      end else if (hdrLast && opCode == eeprom_cmd_pkg::OP_READ) begin
         serialOutEn <= 1'b1;
         serialOut <= eeprom_cmd_pkg::DUMMY_BIT;
         outCnt_q <= 5'h00;
      end else if (state_q == eeprom_cmd_pkg::S_READ && skRise) begin
         if (outCnt_q == 5'h00) begin
            serialOut <= firstWord[15];
            outShift_q <= {firstWord[14:0], 1'b0};
         end else begin
            serialOut <= outShift_q[15];
            outShift_q <= {outShift_q[14:0], 1'b0};
         end
         outCnt_q <= (outCnt_q == 5'(dataLen - 1)) ? 5'h00 : outCnt_q + 5'h01;
      end else if (state_q != eeprom_cmd_pkg::S_READ) begin
         serialOutEn <= 1'b0;
         serialOut <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### eeprom_port_sva.sv
// assertion checker for the three-wire eeprom command port
`timescale 1ns/1ps
`default_nettype none
module eeprom_port_sva #(
   parameter int PROG_CYCLES = 600
) (
   // system
   input wire logic clk_sys,
   input wire logic rstn,
   // pins
   input wire logic chipSelect,
   input wire logic serialClockIn,
   input wire logic serialIn,
   input wire logic widthSelect,
   input wire logic serialOut,
   input wire logic serialOutEn
);
   logic skPrev_q;
   logic [3:0] sinceSk_q;
   logic [31:0] lowWait_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // cycles since the last serial clock rise; reset counts as recent to stay lenient
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         skPrev_q <= 1'b0;
         sinceSk_q <= 4'h0;
      end else begin
         skPrev_q <= serialClockIn;
         if (serialClockIn && !skPrev_q) sinceSk_q <= 4'h0;
         else if (sinceSk_q != 4'hF) sinceSk_q <= sinceSk_q + 4'h1;
      end
   end

   // busy time shown with the clock idle; a host pausing mid-read on zeros would trip it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) lowWait_q <= 32'h0;
      else if (serialOutEn && !serialOut && sinceSk_q == 4'hF) lowWait_q <= lowWait_q + 32'h1;
      else lowWait_q <= 32'h0;
   end

   // select held low for long enough to pass the synchroniser
   sequence csHeldLow;
      (!chipSelect) [*5];
   endsequence

   a_reset_quiet: assert property ($rose(rstn) |-> !serialOutEn && !serialOut)
      else $error("output active after reset");
   a_cs_release: assert property (csHeldLow |-> !serialOutEn)
      else $error("output driven with select low");
   a_first_zero: assert property ($rose(serialOutEn) |-> !serialOut)
      else $error("first driven bit not zero");
   a_en_needs_cs: assert property ($rose(serialOutEn) |-> $past(chipSelect, 2))
      else $error("output enabled without select");
   a_en_rise_cause: assert property ($rose(serialOutEn) |->
      sinceSk_q <= 4'h6 || !$past(chipSelect, 4) || !$past(chipSelect, 5))
      else $error("output enabled without clock or select rise");
   a_out_fall_sk: assert property ($fell(serialOut) && $past(serialOutEn) && serialOutEn
      |-> sinceSk_q <= 4'h6)
      else $error("data changed without a clock rise");
   a_en_drop_cause: assert property ($fell(serialOutEn) |-> sinceSk_q <= 4'h6
      || !$past(chipSelect, 2) || !$past(chipSelect, 3) || !$past(chipSelect, 4))
      else $error("output released without cause");
   a_busy_bounded: assert property (lowWait_q <= PROG_CYCLES + 8)
      else $error("busy status too long");
endmodule
bind three_wire_eeprom_command_port eeprom_port_sva #(
   .PROG_CYCLES(PROG_CYCLES)) i_sva (.clk_sys(clk_sys), .rstn(rstn),
   .chipSelect(chipSelect), .serialClockIn(serialClockIn), .serialIn(serialIn),
   .widthSelect(widthSelect), .serialOut(serialOut), .serialOutEn(serialOutEn));
`default_nettype wire

// ### host_link_model.sv
// host model driving select, serial clock and data toward the eeprom port
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   // system
   input wire logic clk_sys,
   // pins toward the device
   output logic chipSelect,
   output logic serialClockIn,
   output logic serialIn,
   // pins from the device
   input wire logic serialOut,
   input wire logic serialOutEn
);
   // serial clock stands low outside frames
   initial begin
      chipSelect = 1'b0;
      serialClockIn = 1'b0;
      serialIn = 1'b0;
   end

   // select changes just after a system edge; a drop is held 300 ns
   task automatic sel(input logic v);
      @(posedge clk_sys);
      #1 chipSelect = v;
      if (!v) #300;
   endtask

   // n bits msb first at 64 ns a bit; samples on the fall, x when not driven
   task automatic xfer(input logic [31:0] b, input int n, output logic [31:0] rx);
      rx = 32'h0;
      @(posedge clk_sys);
      #13.5; // half-ns offset keeps every pin change off a system edge
      for (int i = n - 1; i >= 0; i--) begin
         serialIn = b[i];
         #32 serialClockIn = 1'b1;
         #32 rx = {rx[30:0], serialOutEn ? serialOut : 1'bx};
         serialClockIn = 1'b0;
      end
      serialIn = ~serialIn; // released data shows no stale level
   endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the three-wire eeprom command port
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PROG = 1000;
   logic clk_sys;
   logic rstn;
   logic widthSelect;
   wire logic chipSelect, serialClockIn, serialIn, serialOut, serialOutEn;
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 94242;
   logic [31:0] rx;
   logic [15:0] d1, d2, fill;
   logic [6:0] a1, a2;

   always #2.5 clk_sys = ~clk_sys;

   three_wire_eeprom_command_port #(.PROG_CYCLES(PROG)) i_dut (
      .clk_sys(clk_sys), .rstn(rstn), .chipSelect(chipSelect),
      .serialClockIn(serialClockIn), .serialIn(serialIn), .widthSelect(widthSelect),
      .serialOut(serialOut), .serialOutEn(serialOutEn));
   host_link_model i_host (.clk_sys(clk_sys), .chipSelect(chipSelect),
      .serialClockIn(serialClockIn), .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEn(serialOutEn));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // start bit, opcode, full-length address, then nd data bits; select stays up
   task automatic cmd(input logic [1:0] op, input logic [6:0] a, input int nd,
                      input logic [15:0] d);
      logic [31:0] b;
      int aw;
      aw = widthSelect ? 6 : 7;
      b = 32'({1'b1, op});
      b = (b << aw) | (32'(a) & ((32'h1 << aw) - 32'h1));
      b = (b << nd) | (32'(d) & ((32'h1 << nd) - 32'h1));
      i_host.sel(1'b1);
      i_host.xfer(b, 3 + aw + nd, rx);
   endtask

   // special command: selector in the top two address bits, low four bits random
   task automatic spc(input logic [1:0] s, input int nd, input logic [15:0] d);
      cmd(2'b00, (7'(s) << (widthSelect ? 4 : 5)) | 7'($random(seed) & 15), nd, d);
   endtask

   // drop select and raise it again; if busy is expected it must read 0 then turn to 1, else no status is driven
   task automatic poll(input logic expBusy);
      int n;
      i_host.sel(1'b0);
      i_host.sel(1'b1);
      repeat (8) @(posedge clk_sys);
      #1;
      check(serialOutEn, expBusy);
      if (expBusy) begin
         check(serialOut, 1'b0);
         n = 0;
         while (serialOut !== 1'b1 && n < PROG + 20) begin
            @(posedge clk_sys);
            n++;
         end
         check(serialOut, 1'b1);
      end
      i_host.sel(1'b0);
   endtask

   // read one unit; the bit under the last address bit is the dummy
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      cmd(2'b10, a, 0, 16'h0);
      check(rx[0], 1'b0);
      i_host.xfer(32'h0, widthSelect ? 16 : 8, rx);
      check(rx, 32'(exp));
      i_host.sel(1'b0);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   initial begin
      clk_sys = 1'b0;
      rstn = 1'b0;
      widthSelect = 1'b1;
      a1 = 7'($random(seed) & 63);
      a2 = a1 ^ 7'h15;
      d1 = 16'($random(seed));
      d2 = ~d1;
      fill = 16'($random(seed));
      repeat (20) @(posedge clk_sys);
      #1 rstn = 1'b1;
      repeat (5) @(posedge clk_sys);
      spc(2'b10, 0, 16'h0);
      poll(1'b0);
      spc(2'b11, 0, 16'h0);
      poll(1'b0);
      spc(2'b10, 0, 16'h0);
      poll(1'b1);
      rd(a1, 16'hFFFF);
      done("power-on lock and clear all");
      i_host.sel(1'b1);
      i_host.xfer(32'h0, 3, rx);
      cmd(2'b01, a1, 16, d1);
      poll(1'b1);
      rd(a1, d1);
      cmd(2'b01, a2, 0, 16'h0);
      poll(1'b0);
      rd(a2, 16'hFFFF);
      cmd(2'b11, a1, 0, 16'h0);
      poll(1'b1);
      rd(a1, 16'hFFFF);
      done("write, abort, erase");
      spc(2'b01, 16, fill);
      poll(1'b1);
      rd(a2, fill);
      cmd(2'b01, a1, 16, d1);
      i_host.sel(1'b0);
      cmd(2'b01, a2, 16, d2);
      poll(1'b1);
      rd(a1, d1);
      rd(a2, fill);
      done("fill all and busy ignore");
      spc(2'b00, 0, 16'h0);
      poll(1'b0);
      cmd(2'b01, a1, 16, d2);
      poll(1'b0);
      rd(a1, d1);
      done("lock");
      widthSelect = 1'b0;
      spc(2'b11, 0, 16'h0);
      poll(1'b0);
      cmd(2'b01, {a1[5:0], 1'b0}, 8, {8'h00, d2[7:0]});
      poll(1'b1);
      rd({a1[5:0], 1'b0}, {8'h00, d2[7:0]});
      rd({a1[5:0], 1'b1}, {8'h00, d1[15:8]});
      spc(2'b00, 0, 16'h0);
      poll(1'b0);
      done("byte mode");
      tally_and_finish;
   end

   // watchdog: the tests need well under 400 us
   initial begin
      #400000;
      error_cnt++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
